/* File: src/pkt_framer_pkg.sv */
// shared constants, state type and crc step for the packet framer
package pkt_framer_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] ERR_OFS = 12'h008;
  // control fields
  localparam int CTRL_FLOW_EN_BIT = 0;
  localparam int CTRL_PRIO_LSB = 1;
  localparam int CTRL_FLOW_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // status fields
  localparam int STAT_RX_SEQ_LSB = 0;
  localparam int STAT_TX_SEQ_LSB = 8;
  // sticky error bits
  localparam int ERR_CRC_BIT = 0;
  localparam int ERR_SEQ_BIT = 1;
  localparam int ERR_ALIGN_BIT = 2;
  localparam int ERR_OVERSIZE_BIT = 3;
  localparam logic [3:0] ERR_RST = 4'h0;
  // priority levels
  localparam logic [1:0] PRIO_LOWEST = 2'h0;
  localparam logic [1:0] PRIO_MEDIUM = 2'h1;
  localparam logic [1:0] PRIO_HIGH = 2'h2;
  localparam logic [1:0] PRIO_HIGHEST = 2'h3;
  // crc and framing
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_FIRST_MASK = 16'h03FF;
  localparam logic [15:0] PAD_WORD = 16'h0000;
  localparam logic [4:0] SEQ_RST = 5'h00;
  localparam logic [7:0] EARLY_HW = 8'h28;
  localparam logic [7:0] MAX_CONTENT_HW = 8'h88;
  localparam logic [8:0] RX_EARLY_POS = 9'h029;

  typedef enum logic [2:0] {
    S_DATA = 3'b000,
    S_ECRC = 3'b001,
    S_FCRC = 3'b010,
    S_PAD = 3'b011,
    S_DROP = 3'b100
  } tx_state_e;

  // sixteen data bits, msb first, into the running check
  function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic [15:0] data);
    logic [15:0] c;
    logic fb;
    c = crc;
    for (int i = 15; i >= 0; i--) begin
      fb = c[15] ^ data[i];
      c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction : crc16_step
endpackage : pkt_framer_pkg

/* File: src/serial_packet_framer_crc16.sv */
// packet framer and checker with header, crc16, early crc and pad
`timescale 1ns/1ps
module serial_packet_framer_crc16
  import pkt_framer_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmit content from upper layers
  input wire logic tx_in_valid,
  input wire logic [15:0] tx_in_data,
  input wire logic tx_in_last,
  output logic tx_in_ready,
  // transmit framed stream to coding sublayer
  output logic tx_out_valid,
  output logic [15:0] tx_out_data,
  output logic tx_out_last,
  input wire logic tx_out_ready,
  // receive framed stream from coding sublayer
  input wire logic rx_in_valid,
  input wire logic [15:0] rx_in_data,
  input wire logic rx_in_last,
  // receive stream and header towards upper layers
  output logic rx_out_valid,
  output logic [15:0] rx_out_data,
  output logic rx_out_last,
  output logic [4:0] rx_seq,
  output logic [1:0] rx_prio,
  output logic rx_critical_flow_bit,
  output logic rx_early_ok,
  output logic rx_crc_err,
  output logic rx_seq_err,
  output logic rx_align_err
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ---------------- registers over apb ----------------
  logic [3:0] ctrl_reg;
  logic [3:0] err_reg;
  logic [3:0] err_next;
  logic [3:0] err_set;
  logic [31:0] prdata_next;
  logic [4:0] tx_seq_reg;
  logic [4:0] exp_seq_reg;

  wire sel_ctrl = (paddr == CTRL_OFS);
  wire sel_stat = (paddr == STATUS_OFS);
  wire sel_err = (paddr == ERR_OFS);
  wire mapped = sel_ctrl | sel_stat | sel_err;
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite;
  wire flow_en = ctrl_reg[CTRL_FLOW_EN_BIT];
  wire [1:0] cfg_prio = ctrl_reg[CTRL_PRIO_LSB +: 2];
  // bit forced to zero when unsupported
  wire flow_eff = flow_en & ctrl_reg[CTRL_FLOW_BIT];
  wire [3:0] err_clr = (apb_wr & sel_err) ? pwdata[3:0] : 4'h0;

  assign prdata_next = sel_ctrl ? {28'h0000000, ctrl_reg} :
                       sel_stat ? {19'h00000, tx_seq_reg, 3'h0, exp_seq_reg} :
                       sel_err ? {28'h0000000, err_reg} : 32'h00000000;
  // set wins over a clear in the same cycle
  assign err_next = (err_reg & ~err_clr) | err_set;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RST;
      err_reg <= ERR_RST;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      if (apb_wr && sel_ctrl) begin
        ctrl_reg <= pwdata[3:0];
      end
      err_reg <= err_next;
      pready <= apb_setup;
      pslverr <= apb_setup & ~mapped;
      if (apb_setup) begin
        prdata <= prdata_next;
      end
    end
  end

  // ---------------- transmit framer ----------------
  tx_state_e tx_state_reg, tx_state_next;
  logic [7:0] tx_cnt_reg, tx_cnt_next;
  logic [15:0] tx_crc_reg, tx_crc_next;
  logic tx_first_reg, tx_first_next;
  logic tx_par_reg, tx_par_next;
  logic [4:0] tx_seq_next;
  logic load;
  logic [15:0] word;
  logic word_last;
  logic oversize;
  logic out_valid_next;
  logic out_first_reg;

  wire slot_free = ~tx_out_valid | tx_out_ready;
  wire take = tx_in_ready & tx_in_valid;
  wire [7:0] cnt_inc = tx_cnt_reg + 8'h01;
  // identifier, reserved pair, flow bit, priority
  wire [15:0] hdr_word = {tx_seq_reg, 2'b00, flow_eff, cfg_prio, tx_in_data[5:0]};
  // identifier and adjacent reserved bit fed as zero
  wire [15:0] first_feed = hdr_word & CRC_FIRST_MASK;

  always_comb begin
    tx_state_next = tx_state_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_crc_next = tx_crc_reg;
    tx_first_next = tx_first_reg;
    tx_par_next = tx_par_reg;
    tx_seq_next = tx_seq_reg;
    load = 1'b0;
    word = PAD_WORD;
    word_last = 1'b0;
    oversize = 1'b0;
    case (tx_state_reg)
      S_DATA: begin
        if (take) begin
          load = 1'b1;
          tx_cnt_next = tx_first_reg ? 8'h01 : cnt_inc;
          if (tx_first_reg) begin
            word = hdr_word;
            tx_crc_next = crc16_step(CRC_INIT, first_feed);
            tx_seq_next = tx_seq_reg + 5'h01;
          end else begin
            word = tx_in_data;
            tx_crc_next = crc16_step(tx_crc_reg, tx_in_data);
          end
          tx_first_next = 1'b0;
          if (tx_in_last) begin
            // final crc right after last field
            tx_state_next = S_FCRC;
          end else if (tx_cnt_next == MAX_CONTENT_HW) begin
            // cut off at the size limit
            oversize = 1'b1;
            tx_state_next = S_DROP;
          end else if (tx_cnt_next == EARLY_HW) begin
            tx_state_next = S_ECRC;
          end
        end
      end
      S_ECRC: begin
        if (slot_free) begin
          load = 1'b1;
          word = tx_crc_reg;
          // early crc joins the running check
          tx_crc_next = crc16_step(tx_crc_reg, tx_crc_reg);
          tx_state_next = S_DATA;
        end
      end
      S_FCRC: begin
        if (slot_free) begin
          load = 1'b1;
          word = tx_crc_reg;
          word_last = tx_par_reg;
          tx_first_next = tx_par_reg;
          // pad when even count of halfwords ahead of the crc
          tx_state_next = tx_par_reg ? S_DATA : S_PAD;
        end
      end
      S_PAD: begin
        if (slot_free) begin
          load = 1'b1;
          word = PAD_WORD;
          word_last = 1'b1;
          tx_first_next = 1'b1;
          tx_state_next = S_DATA;
        end
      end
      S_DROP: begin
        if (take && tx_in_last) begin
          tx_state_next = S_FCRC;
        end
      end
      default: begin
        tx_state_next = S_DATA;
      end
    endcase
    if (load) begin
      tx_par_next = word_last ? 1'b0 : ~tx_par_reg;
    end
  end

  assign out_valid_next = load | (tx_out_valid & ~tx_out_ready);
  // ready is registered, so content moves at most every other cycle, except in S_DROP, where it can be taken every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg <= S_DATA;
      tx_cnt_reg <= 8'h00;
      tx_crc_reg <= CRC_INIT;
      tx_first_reg <= 1'b1;
      tx_par_reg <= 1'b0;
      tx_seq_reg <= SEQ_RST;
      tx_out_valid <= 1'b0;
      tx_out_data <= PAD_WORD;
      tx_out_last <= 1'b0;
      out_first_reg <= 1'b0;
      tx_in_ready <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_crc_reg <= tx_crc_next;
      tx_first_reg <= tx_first_next;
      tx_par_reg <= tx_par_next;
      tx_seq_reg <= tx_seq_next;
      tx_out_valid <= out_valid_next;
      tx_in_ready <= ((tx_state_next == S_DATA) | (tx_state_next == S_DROP)) & ~out_valid_next;
      if (load) begin
        tx_out_data <= word;
        tx_out_last <= word_last;
        out_first_reg <= tx_first_reg & (tx_state_reg == S_DATA);
      end
    end
  end

  // ---------------- receive checker ----------------
  logic [8:0] rx_cnt_reg;
  logic [15:0] rx_crc_reg;
  logic rx_first_reg;
  logic rx_seq_ok_reg;
  logic rx_crc_next_err;
  logic rx_seq_next;
  logic rx_align_next;

  wire [8:0] rx_cnt_next = rx_first_reg ? 9'h001 : rx_cnt_reg + 9'h001;
  wire [15:0] rx_feed = rx_first_reg ? (rx_in_data & CRC_FIRST_MASK) : rx_in_data;
  wire [15:0] rx_crc_upd = crc16_step(rx_first_reg ? CRC_INIT : rx_crc_reg, rx_feed);
  wire rx_at_early = rx_in_valid & ~rx_in_last & (rx_cnt_next == RX_EARLY_POS);
  wire rx_at_end = rx_in_valid & rx_in_last;
  wire rx_seq_bad = rx_in_valid & rx_first_reg & (rx_in_data[15:11] != exp_seq_reg);
  // either check failing flags an error
  assign rx_crc_next_err = (rx_at_early | rx_at_end) & (rx_crc_upd != 16'h0000);
  assign rx_seq_next = rx_seq_bad;
  // frame must end on a 32-bit boundary
  assign rx_align_next = rx_at_end & rx_cnt_next[0];
  assign err_set = {oversize, rx_align_next, rx_seq_next, rx_crc_next_err};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_reg <= 9'h000;
      rx_crc_reg <= CRC_INIT;
      rx_first_reg <= 1'b1;
      rx_seq_ok_reg <= 1'b0;
      exp_seq_reg <= SEQ_RST;
      rx_out_valid <= 1'b0;
      rx_out_data <= 16'h0000;
      rx_out_last <= 1'b0;
      rx_seq <= SEQ_RST;
      rx_prio <= PRIO_LOWEST;
      rx_critical_flow_bit <= 1'b0;
      rx_early_ok <= 1'b0;
      rx_crc_err <= 1'b0;
      rx_seq_err <= 1'b0;
      rx_align_err <= 1'b0;
    end else begin
      rx_out_valid <= rx_in_valid;
      rx_early_ok <= 1'b0;
      rx_crc_err <= rx_crc_next_err;
      rx_seq_err <= rx_seq_next;
      rx_align_err <= rx_align_next;
      if (rx_in_valid) begin
        rx_out_data <= rx_in_data;
        rx_out_last <= rx_in_last;
        rx_cnt_reg <= rx_cnt_next;
        rx_crc_reg <= rx_crc_upd;
        rx_first_reg <= rx_in_last;
        if (rx_first_reg) begin
          rx_seq <= rx_in_data[15:11];
          rx_prio <= rx_in_data[7:6];
          rx_critical_flow_bit <= rx_in_data[8] & flow_en;
          rx_seq_ok_reg <= ~rx_seq_bad;
        end
        // header confirmed before the packet ends
        rx_early_ok <= rx_at_early & (rx_crc_upd == 16'h0000);
        if (rx_at_end && (rx_crc_upd == 16'h0000) && (rx_seq_ok_reg | (rx_first_reg & ~rx_seq_bad))) begin
          exp_seq_reg <= exp_seq_reg + 5'h01;
        end
      end
    end
  end

  // ---------------- checks ----------------
  sequence s_first_load;
    (tx_state_reg == S_DATA) && take && tx_first_reg;
  endsequence
  property p_rsvd_zero;
    tx_out_valid && out_first_reg |-> tx_out_data[10:9] == 2'b00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved header bits not zero");
  property p_flow_off;
    s_first_load and !flow_en |=> tx_out_data[8] == 1'b0;
  endproperty
  a_flow_off: assert property (p_flow_off) else $error("flow bit sent while unsupported");
  property p_prio;
    s_first_load |=> tx_out_data[7:6] == $past(cfg_prio);
  endproperty
  a_prio: assert property (p_prio) else $error("priority field wrong");
  property p_seq_inc;
    s_first_load |=> (tx_seq_reg == $past(tx_seq_reg) + 5'h01) && (tx_out_data[15:11] == $past(tx_seq_reg));
  endproperty
  a_seq_inc: assert property (p_seq_inc) else $error("identifier not consecutive");
  property p_crc_first;
    s_first_load |=> tx_crc_reg == crc16_step(CRC_INIT, $past(first_feed));
  endproperty
  a_crc_first: assert property (p_crc_first) else $error("crc not preset per packet");
  property p_early_crc;
    (tx_state_reg == S_DATA) && take && !tx_in_last && !tx_first_reg && (cnt_inc == EARLY_HW) |=> (tx_state_reg == S_ECRC)
      ##[1:100] ((tx_state_reg == S_DATA) && tx_out_valid && !tx_out_last && (tx_crc_reg == 16'h0000));
  endproperty
  a_early_crc: assert property (p_early_crc) else $error("early crc not inserted");
  property p_pad;
    (tx_state_reg == S_FCRC) && load && !tx_par_reg |=> (tx_state_reg == S_PAD) && !tx_out_last;
  endproperty
  a_pad: assert property (p_pad) else $error("pad missing after odd length");
  property p_max_len;
    tx_cnt_reg <= MAX_CONTENT_HW;
  endproperty
  a_max_len: assert property (p_max_len) else $error("packet over size limit");
  property p_rx_err;
    (rx_at_early || rx_at_end) && (rx_crc_upd != 16'h0000) |=> rx_crc_err;
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("crc error not flagged");
  property p_apb_ready;
    apb_setup |=> pready && (pslverr == !$past(mapped));
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb answer wrong");

endmodule : serial_packet_framer_crc16

/* File: verif/peer_port_model.sv */
// peer port model: sinks the framed stream and loops it back
`timescale 1ns/1ps
module peer_port_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // framed stream from the block
  input wire logic tx_out_valid,
  input wire logic [15:0] tx_out_data,
  input wire logic tx_out_last,
  output logic tx_out_ready,
  // test controls: stall, corrupt header or last word
  input wire logic stall_en,
  input wire logic [1:0] flip_sel,
  input wire logic [15:0] flip_mask,
  // framed stream back into the block
  output logic rx_in_valid,
  output logic [15:0] rx_in_data,
  output logic rx_in_last
);
  logic first_reg;
  logic take;
  logic flip;
  assign take = tx_out_valid && tx_out_ready;
  assign flip = (flip_sel == 2'h1 && first_reg) || (flip_sel == 2'h2 && tx_out_last);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_out_ready <= 1'b0;
      rx_in_valid <= 1'b0;
      rx_in_data <= 16'h0000;
      rx_in_last <= 1'b0;
      first_reg <= 1'b1;
    end else begin
      tx_out_ready <= stall_en ? ($urandom_range(3) == 0) : 1'b1;
      rx_in_valid <= take;
      // idle line flips to the inverse every cycle, so it shows a stale copy on every other idle cycle
      rx_in_data <= take ? (tx_out_data ^ (flip ? flip_mask : 16'h0000)) : ~rx_in_data;
      rx_in_last <= take && tx_out_last;
      if (take) begin
        first_reg <= tx_out_last;
      end
    end
  end
endmodule : peer_port_model

/* File: verif/test_serial_packet_framer_crc16.sv */
// self-checking bench for the packet framer with a looping peer
`timescale 1ns/1ps
module test_serial_packet_framer_crc16
  import pkt_framer_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic tx_in_valid, tx_in_last, tx_in_ready, tx_out_valid, tx_out_last, tx_out_ready;
  logic [15:0] tx_in_data, tx_out_data, rx_in_data, rx_out_data, flip_mask;
  logic rx_in_valid, rx_in_last, rx_out_valid, rx_out_last, rx_critical_flow_bit, rx_early_ok;
  logic rx_crc_err, rx_seq_err, rx_align_err, stall_en;
  logic [4:0] rx_seq, exp_tx, exp_rx;
  logic [1:0] rx_prio, flip_sel;
  logic [15:0] cont [0:139];
  logic [15:0] exp_q [$];
  logic [15:0] got_q [$];
  logic [15:0] rx_q [$];
  int n_errors, samples_checked, n_early, n_crc, n_serr, n_align, n_rxlast, last_at;

  serial_packet_framer_crc16 i_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tx_in_valid, .tx_in_data, .tx_in_last, .tx_in_ready, .tx_out_valid, .tx_out_data,
    .tx_out_last, .tx_out_ready, .rx_in_valid, .rx_in_data, .rx_in_last, .rx_out_valid, .rx_out_data,
    .rx_out_last, .rx_seq, .rx_prio, .rx_critical_flow_bit, .rx_early_ok, .rx_crc_err, .rx_seq_err, .rx_align_err);
  peer_port_model i_peer (.clk, .rst_n, .tx_out_valid, .tx_out_data, .tx_out_last, .tx_out_ready,
    .stall_en, .flip_sel, .flip_mask, .rx_in_valid, .rx_in_data, .rx_in_last);

  always #50 clk = ~clk;

  always @(posedge clk) begin
    if (tx_out_valid === 1'b1 && tx_out_ready === 1'b1) begin
      if (tx_out_last === 1'b1) last_at = got_q.size();
      got_q.push_back(tx_out_data);
    end
    n_early += (rx_early_ok === 1'b1);
    n_crc += (rx_crc_err === 1'b1);
    n_serr += (rx_seq_err === 1'b1);
    n_align += (rx_align_err === 1'b1);
    n_rxlast += (rx_out_valid === 1'b1 && rx_out_last === 1'b1);
    if (rx_out_valid === 1'b1) rx_q.push_back(rx_out_data);
  end

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp16

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp32

  task automatic end_of_test();
    $display("checked %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: bus answer missing", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // bit-serial reference, msb first
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction : crc_upd

  task automatic build_exp(input int m, input logic [4:0] sq, input logic [1:0] pr, input logic cf);
    logic [15:0] w;
    logic [15:0] c;
    exp_q.delete();
    c = CRC_INIT;
    for (int i = 0; i < m; i++) begin
      w = (i == 0) ? {sq, 2'b00, cf, pr, cont[0][5:0]} : cont[i];
      exp_q.push_back(w);
      c = crc_upd(c, (i == 0) ? (w & CRC_FIRST_MASK) : w);
      if (i == 39 && m > 40) begin
        exp_q.push_back(c);
        c = crc_upd(c, c);
      end
    end
    exp_q.push_back(c);
    if (exp_q.size() % 2) exp_q.push_back(PAD_WORD);
  endtask : build_exp

  task automatic run_pkt(input int n, input logic [1:0] pr, input logic cf, input logic cfen, input logic [1:0] sel);
    logic [31:0] r;
    logic e;
    logic serr;
    logic bad;
    int m;
    int t;
    m = (n > 136) ? 136 : n;
    bad = (sel == 2'h2);
    serr = (exp_tx != exp_rx);
    apb(1'b1, CTRL_OFS, {28'h0, cf, pr, cfen}, r, e);
    apb(1'b0, STATUS_OFS, 32'h0, r, e);
    cmp32(r, {19'h0, exp_tx, 3'h0, exp_rx}, "status ids");
    for (int i = 0; i < n; i++) cont[i] = 16'($urandom);
    build_exp(m, exp_tx, pr, cf & cfen);
    got_q.delete();
    rx_q.delete();
    {n_early, n_crc, n_serr, n_align, n_rxlast, last_at} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd0, -32'sd1};
    stall_en <= 1'($urandom);
    flip_sel <= sel;
    flip_mask <= bad ? 16'h0001 : 16'h0400;
    for (int i = 0; i < n; i++) begin
      tx_in_valid <= 1'b1;
      tx_in_data <= cont[i];
      tx_in_last <= (i == n - 1);
      t = 0;
      do begin
        @(posedge clk);
        t++;
      end while (tx_in_ready !== 1'b1 && t < 200);
      if (tx_in_ready !== 1'b1) begin
        n_errors++;
        $display("unexpected at %0t: content word not taken", $time);
      end
    end
    tx_in_valid <= 1'b0;
    t = 0;
    while (n_rxlast == 0 && t < 3000) begin
      @(posedge clk);
      t++;
    end
    if (n_rxlast == 0) begin
      n_errors++;
      $display("unexpected at %0t: looped frame never ended", $time);
    end
    repeat (3) @(posedge clk);
    cmp32(got_q.size(), exp_q.size(), "frame length");
    cmp32(last_at, exp_q.size() - 1, "end marker");
    foreach (exp_q[i]) cmp16(i < got_q.size() ? got_q[i] : ~exp_q[i], exp_q[i], "frame word");
    cmp32(rx_q.size(), exp_q.size(), "looped length");
    foreach (exp_q[i]) cmp16(i < rx_q.size() ? rx_q[i] : ~exp_q[i], exp_q[i] ^ ((sel == 2'h1 && i == 0) ? 16'h0400 :
      (bad && i == exp_q.size() - 1) ? 16'h0001 : 16'h0000), "looped word");
    // word 41 of a 40-halfword packet is its final crc, still checked there
    cmp32(n_early, 32'(m >= 40), "early ok");
    cmp32(n_crc, 32'(bad), "crc error");
    cmp32(n_serr, 32'(serr), "seq error");
    cmp32(n_align, 0, "align error");
    cmp32({rx_seq, rx_prio, rx_critical_flow_bit}, {exp_tx, pr, cf & cfen}, "rx header");
    apb(1'b0, ERR_OFS, 32'h0, r, e);
    cmp32(r, {28'h0, n > 136, 1'b0, serr, bad}, "sticky errors");
    apb(1'b1, ERR_OFS, 32'h0000000F, r, e);
    if (!bad && !serr) exp_rx++;
    exp_tx++;
    $display("test done: %0d halfwords, mode %0d", n, sel);
  endtask : run_pkt

  initial begin
    #6000000;
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    logic [31:0] r;
    logic e;
    int lens [10];
    {clk, rst_n, psel, penable, pwrite, tx_in_valid, tx_in_last, stall_en} = 8'h00;
    {paddr, pwdata, tx_in_data, flip_mask, flip_sel} = '0;
    {n_errors, samples_checked} = {32'd0, 32'd0};
    exp_tx = SEQ_RST;
    exp_rx = SEQ_RST;
    void'($urandom(56));
    lens = '{1, 2, 39, 40, 41, 42, 136, 140, 0, 0};
    lens[8] = 1 + $urandom_range(135);
    lens[9] = 1 + $urandom_range(135);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    apb(1'b0, 12'h00C, 32'h0, r, e);
    cmp32({r[30:0], e}, 32'h1, "unmapped read");
    apb(1'b0, CTRL_OFS, 32'h0, r, e);
    cmp32(r, {28'h0, CTRL_RST}, "ctrl reset");
    apb(1'b0, ERR_OFS, 32'h0, r, e);
    cmp32(r, {28'h0, ERR_RST}, "err reset");
    $display("test done: registers");
    for (int k = 0; k < 10; k++) run_pkt(lens[k], 2'(k), k[1], k[2], 2'h0);
    run_pkt(10, PRIO_HIGH, 1'b1, 1'b1, 2'h1);
    run_pkt(45, PRIO_LOWEST, 1'b0, 1'b1, 2'h2);
    run_pkt(3, PRIO_HIGHEST, 1'b1, 1'b0, 2'h0);
    end_of_test();
  end
endmodule : test_serial_packet_framer_crc16
